// >>> scs_axil.sv
`timescale 1ns/1ps
`default_nettype none
module scs_axil #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write channels
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read channels
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// register side
	output logic reg_wr,
	output logic [ADDR_W-1:0] reg_waddr,
	output logic [31:0] reg_wdata,
	output logic [3:0] reg_wstrb,
	input wire logic reg_wok,
	output logic [ADDR_W-1:0] reg_raddr,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rok
);

	logic aw_held;
	logic w_held;
	logic next_aw_held;
	logic next_w_held;
	logic next_bvalid;
	logic next_rvalid;

	assign reg_wr = aw_held && w_held && !bvalid;
	assign reg_raddr = araddr;
	assign next_aw_held = aw_held ? !reg_wr : (awvalid && awready);
	assign next_w_held = w_held ? !reg_wr : (wvalid && wready);
	assign next_bvalid = bvalid ? !bready : reg_wr;
	assign next_rvalid = rvalid ? !rready : (arvalid && arready);

	// ----------------------------------------
	// write path: address and data in either order
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
			reg_waddr <= '0;
			reg_wdata <= 32'h0;
			reg_wstrb <= 4'h0;
		end
		else
		begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			awready <= !next_aw_held && !next_bvalid;
			wready <= !next_w_held && !next_bvalid;
			bvalid <= next_bvalid;
			if (awvalid && awready)
				reg_waddr <= awaddr;
			if (wvalid && wready)
			begin
				reg_wdata <= wdata;
				reg_wstrb <= wstrb;
			end
			if (reg_wr)
				bresp <= reg_wok ? 2'h0 : 2'h2;
		end
	end

	// ----------------------------------------
	// read path: data captured at the address handshake
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= 2'h0;
		end
		else
		begin
			arready <= !next_rvalid;
			rvalid <= next_rvalid;
			if (arvalid && arready)
			begin
				rdata <= reg_rdata;
				rresp <= reg_rok ? 2'h0 : 2'h2;
			end
		end
	end

endmodule
`default_nettype wire

// >>> scs_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none
// power-of-two tick divider: one tick_out per 2**ratio_log input ticks
module scs_clkdiv #(
	parameter int LOG_W = 4,
	parameter int CNT_W = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// ticks
	input wire logic tick_in,
	input wire logic [LOG_W-1:0] ratio_log,
	output logic tick_out
);

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] limit;

	assign limit = CNT_W'((1 << ratio_log) - 1);

	// a ratio change mid-count takes effect at once; the >= avoids a long wrap
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt <= '0;
			tick_out <= 1'b0;
		end
		else if (tick_in)
		begin
			tick_out <= (cnt >= limit);
			cnt <= (cnt >= limit) ? '0 : cnt + CNT_W'(1);
		end
		else
			tick_out <= 1'b0;
	end

endmodule
`default_nettype wire

// >>> scs_pkg.sv
`default_nettype none
`include "scs_regs.svh"
package scs_pkg;

	typedef enum logic [2:0] {REG_PROTECT, REG_CTRL0, REG_CTRL1, REG_FAST0, REG_FAST2,
		REG_STOPDET, REG_STATUS, REG_NONE} scs_reg_e;
	typedef enum logic [1:0] {SRC_EXT, SRC_LOW, SRC_FAST} scs_src_e;
	typedef enum logic [1:0] {FOSC_OFF, FOSC_WARM, FOSC_RUN} scs_fosc_e;

	function automatic scs_reg_e reg_decode(input logic [7:0] addr);
		case (addr)
			`SCS_OFF_PROTECT: reg_decode = REG_PROTECT;
			`SCS_OFF_CTRL0: reg_decode = REG_CTRL0;
			`SCS_OFF_CTRL1: reg_decode = REG_CTRL1;
			`SCS_OFF_FAST0: reg_decode = REG_FAST0;
			`SCS_OFF_FAST2: reg_decode = REG_FAST2;
			`SCS_OFF_STOPDET: reg_decode = REG_STOPDET;
			`SCS_OFF_STATUS: reg_decode = REG_STATUS;
			default: reg_decode = REG_NONE;
		endcase
	endfunction

endpackage
`default_nettype wire

// >>> scs_regs.svh
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SCS_OFF_PROTECT 8'h00
`define SCS_OFF_CTRL0 8'h04
`define SCS_OFF_CTRL1 8'h08
`define SCS_OFF_FAST0 8'h0c
`define SCS_OFF_FAST2 8'h10
`define SCS_OFF_STOPDET 8'h14
`define SCS_OFF_STATUS 8'h18

// ----------------------------------------
// field positions
// ----------------------------------------
`define SCS_BIT_UNLOCK 0
`define SCS_BIT_LOW_STOP 4
`define SCS_BIT_CPU_HI_LSB 6
`define SCS_BIT_CPU_LO 6
`define SCS_BIT_FAST_EN 0
`define SCS_BIT_FAST_SEL 1
`define SCS_BIT_SRC_SEL 2

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define SCS_RST_REG 8'h00
`define SCS_CLK_PERIOD_NS 50
`define SCS_FAST_STAB_NS 10000
`define SCS_LOW_OSC_LOG 4'h7
`define SCS_CPU_FORCED_LOG 4'h3

`endif

// >>> scs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "scs_regs.svh"
module scs_top #(
	parameter int FAST_STAB_NS = `SCS_FAST_STAB_NS,
	parameter logic [3:0] LOW_OSC_LOG = `SCS_LOW_OSC_LOG,
	parameter logic [3:0] CPU_FORCED_LOG = `SCS_CPU_FORCED_LOG
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// external clock source tick
	input wire logic ext_clk_tick,
	// oscillator and clock tree control
	output logic low_osc_run,
	output logic fast_osc_run,
	output logic fast_osc_ready,
	output logic [1:0] sys_clk_src,
	output logic [3:0] fast_div_log,
	output logic [3:0] cpu_div_log,
	output logic cpu_tick
);

	localparam int STAB_CYC = (FAST_STAB_NS + `SCS_CLK_PERIOD_NS - 1) / `SCS_CLK_PERIOD_NS;
	localparam int STAB_W = $clog2(STAB_CYC + 1);
	localparam int STAB_BOUND = STAB_CYC + 2;

	logic [7:0] write_protect_reg;
	logic [7:0] sys_clock_ctrl0;
	logic [7:0] sys_clock_ctrl1;
	logic [7:0] fast_osc_ctrl0;
	logic [7:0] fast_osc_ctrl2;
	logic [7:0] osc_stop_detect_reg;
	logic reg_wr;
	logic [7:0] reg_waddr;
	logic [31:0] reg_wdata;
	logic [3:0] reg_wstrb;
	logic reg_wok;
	logic [7:0] reg_raddr;
	logic [31:0] reg_rdata;
	logic reg_rok;
	scs_pkg::scs_reg_e wsel;
	scs_pkg::scs_reg_e rsel;
	logic wr_lane;
	logic clock_reg_write_unlock;
	logic [7:0] status;
	scs_pkg::scs_fosc_e fosc_state;
	scs_pkg::scs_fosc_e next_fosc_state;
	logic [STAB_W-1:0] stab_cnt;
	logic low_tick;
	logic fast_tick;
	logic src_tick;
	scs_pkg::scs_src_e next_src;

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	scs_axil #(.ADDR_W(8)) u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.reg_wr(reg_wr),
		.reg_waddr(reg_waddr),
		.reg_wdata(reg_wdata),
		.reg_wstrb(reg_wstrb),
		.reg_wok(reg_wok),
		.reg_raddr(reg_raddr),
		.reg_rdata(reg_rdata),
		.reg_rok(reg_rok)
	);

	assign wsel = scs_pkg::reg_decode(reg_waddr);
	assign rsel = scs_pkg::reg_decode(reg_raddr);
	assign reg_wok = (wsel != scs_pkg::REG_NONE);
	assign reg_rok = (rsel != scs_pkg::REG_NONE);
	// registers are one byte wide, so only lane 0 carries a write
	assign wr_lane = reg_wr && reg_wstrb[0];
	assign clock_reg_write_unlock = write_protect_reg[`SCS_BIT_UNLOCK];

	// ----------------------------------------
	// register file
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			write_protect_reg <= `SCS_RST_REG;
		else if (wr_lane && wsel == scs_pkg::REG_PROTECT)
			write_protect_reg <= reg_wdata[7:0];
	end

	// locked writes still answer okay, they just leave the register alone
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sys_clock_ctrl0 <= `SCS_RST_REG;
			sys_clock_ctrl1 <= `SCS_RST_REG;
			fast_osc_ctrl0 <= `SCS_RST_REG;
			fast_osc_ctrl2 <= `SCS_RST_REG;
			osc_stop_detect_reg <= `SCS_RST_REG;
		end
		else if (wr_lane && clock_reg_write_unlock)
		begin
			case (wsel)
				scs_pkg::REG_CTRL0: sys_clock_ctrl0 <= reg_wdata[7:0];
				scs_pkg::REG_CTRL1: sys_clock_ctrl1 <= reg_wdata[7:0];
				scs_pkg::REG_FAST0: fast_osc_ctrl0 <= reg_wdata[7:0];
				scs_pkg::REG_FAST2: fast_osc_ctrl2 <= reg_wdata[7:0];
				scs_pkg::REG_STOPDET: osc_stop_detect_reg <= reg_wdata[7:0];
				default: ;
			endcase
		end
	end

	assign status = {2'h0, sys_clk_src, (sys_clk_src == 2'(scs_pkg::SRC_FAST)),
		fast_osc_ready, fast_osc_run, low_osc_run};

	always_comb
	begin
		case (rsel)
			scs_pkg::REG_PROTECT: reg_rdata = {24'h0, write_protect_reg};
			scs_pkg::REG_CTRL0: reg_rdata = {24'h0, sys_clock_ctrl0};
			scs_pkg::REG_CTRL1: reg_rdata = {24'h0, sys_clock_ctrl1};
			scs_pkg::REG_FAST0: reg_rdata = {24'h0, fast_osc_ctrl0};
			scs_pkg::REG_FAST2: reg_rdata = {24'h0, fast_osc_ctrl2};
			scs_pkg::REG_STOPDET: reg_rdata = {24'h0, osc_stop_detect_reg};
			scs_pkg::REG_STATUS: reg_rdata = {24'h0, status};
			default: reg_rdata = 32'h0;
		endcase
	end

	// ----------------------------------------
	// fast oscillator start-up
	// ----------------------------------------
	always_comb
	begin
		next_fosc_state = fosc_state;
		case (fosc_state)
			scs_pkg::FOSC_OFF:
				if (fast_osc_ctrl0[`SCS_BIT_FAST_EN])
					next_fosc_state = scs_pkg::FOSC_WARM;
			scs_pkg::FOSC_WARM:
				if (!fast_osc_ctrl0[`SCS_BIT_FAST_EN])
					next_fosc_state = scs_pkg::FOSC_OFF;
				else if (stab_cnt == STAB_W'(STAB_CYC - 1))
					next_fosc_state = scs_pkg::FOSC_RUN;
			scs_pkg::FOSC_RUN:
				if (!fast_osc_ctrl0[`SCS_BIT_FAST_EN])
					next_fosc_state = scs_pkg::FOSC_OFF;
			default: next_fosc_state = scs_pkg::FOSC_OFF;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fosc_state <= scs_pkg::FOSC_OFF;
			stab_cnt <= '0;
			fast_osc_run <= 1'b0;
			fast_osc_ready <= 1'b0;
		end
		else
		begin
			fosc_state <= next_fosc_state;
			stab_cnt <= (fosc_state == scs_pkg::FOSC_WARM) ? stab_cnt + STAB_W'(1) : '0;
			fast_osc_run <= (next_fosc_state != scs_pkg::FOSC_OFF);
			fast_osc_ready <= (next_fosc_state == scs_pkg::FOSC_RUN);
		end
	end

	// ----------------------------------------
	// source selection and dividers
	// ----------------------------------------
	// selecting the fast oscillator before it is stable falls back to the low one
	always_comb
	begin
		if (!osc_stop_detect_reg[`SCS_BIT_SRC_SEL])
			next_src = scs_pkg::SRC_EXT;
		else if (fast_osc_ctrl0[`SCS_BIT_FAST_SEL] && fast_osc_ready)
			next_src = scs_pkg::SRC_FAST;
		else
			next_src = scs_pkg::SRC_LOW;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			low_osc_run <= 1'b0;
			sys_clk_src <= 2'(scs_pkg::SRC_EXT);
			fast_div_log <= 4'h1;
			cpu_div_log <= 4'h0;
		end
		else
		begin
			low_osc_run <= !sys_clock_ctrl1[`SCS_BIT_LOW_STOP];
			sys_clk_src <= 2'(next_src);
			fast_div_log <= {1'b0, fast_osc_ctrl2[2:0]} + 4'h1;
			if (sys_clock_ctrl0[`SCS_BIT_CPU_LO])
				cpu_div_log <= CPU_FORCED_LOG;
			else
				cpu_div_log <= {2'h0, sys_clock_ctrl1[`SCS_BIT_CPU_HI_LSB +: 2]};
		end
	end

	scs_clkdiv #(.LOG_W(4), .CNT_W(8)) u_low_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick_in(low_osc_run),
		.ratio_log(LOW_OSC_LOG),
		.tick_out(low_tick)
	);

	scs_clkdiv #(.LOG_W(4), .CNT_W(8)) u_fast_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick_in(fast_osc_ready),
		.ratio_log(fast_div_log),
		.tick_out(fast_tick)
	);

	always_comb
	begin
		case (sys_clk_src)
			2'(scs_pkg::SRC_EXT): src_tick = ext_clk_tick;
			2'(scs_pkg::SRC_LOW): src_tick = low_tick;
			2'(scs_pkg::SRC_FAST): src_tick = fast_tick;
			default: src_tick = 1'b0;
		endcase
	end

	scs_clkdiv #(.LOG_W(4), .CNT_W(8)) u_cpu_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick_in(src_tick),
		.ratio_log(cpu_div_log),
		.tick_out(cpu_tick)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_fast_enabled;
		$rose(fast_osc_ctrl0[`SCS_BIT_FAST_EN]) && fosc_state == scs_pkg::FOSC_OFF;
	endsequence

	a_unlocked_write_taken: assert property (
		wr_lane && clock_reg_write_unlock && wsel == scs_pkg::REG_CTRL1
		|=> sys_clock_ctrl1 == $past(reg_wdata[7:0]))
		else $error("unlocked write not stored");
	a_locked_write_ignored: assert property (
		wr_lane && !clock_reg_write_unlock && wsel == scs_pkg::REG_FAST0
		|=> $stable(fast_osc_ctrl0))
		else $error("locked write changed register");
	// the reset edge itself still clears the run flag, so both cycles must be out of reset
	a_low_osc_run: assert property (
		(aresetn && !sys_clock_ctrl1[`SCS_BIT_LOW_STOP]) [*2] |-> low_osc_run && status[0])
		else $error("low oscillator not running");
	a_fast_div_ratio: assert property (
		fast_osc_ctrl2[2:0] == 3'h0 [*2] |-> fast_div_log == 4'h1)
		else $error("fast divider not divide by two");
	a_fast_osc_start: assert property (
		s_fast_enabled |=> fast_osc_run ##0 !fast_osc_ready
		##[1:STAB_BOUND] (fast_osc_ready || !fast_osc_ctrl0[`SCS_BIT_FAST_EN]))
		else $error("fast oscillator start-up wrong");
	a_fast_select: assert property (
		osc_stop_detect_reg[`SCS_BIT_SRC_SEL] && fast_osc_ctrl0[`SCS_BIT_FAST_SEL]
		&& fast_osc_ready |=> sys_clk_src == 2'(scs_pkg::SRC_FAST))
		else $error("fast oscillator not selected");
	a_onchip_source: assert property (
		!osc_stop_detect_reg[`SCS_BIT_SRC_SEL] |=> sys_clk_src == 2'(scs_pkg::SRC_EXT))
		else $error("on-chip source used while not selected");
	a_cpu_undivided: assert property (
		cpu_div_log == 4'h0 && src_tick |=> cpu_tick)
		else $error("cpu clock divided in no-division mode");
	a_cpu_field_used: assert property (
		!sys_clock_ctrl0[`SCS_BIT_CPU_LO]
		|=> cpu_div_log == {2'h0, $past(sys_clock_ctrl1[7:6])})
		else $error("cpu division field ignored");
	a_cpu_forced_div: assert property (
		sys_clock_ctrl0[`SCS_BIT_CPU_LO] |=> cpu_div_log == CPU_FORCED_LOG)
		else $error("cpu forced division not applied");

endmodule
`default_nettype wire

// >>> system_clock_source_setup_tb.sv
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_setup_tb;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	// short settling time keeps the warm-up wait small
	localparam int STAB_CYC = 10;
	logic aclk;
	logic aresetn;
	logic [7:0] awaddr;
	logic [7:0] araddr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	logic awvalid, wvalid, bready, arvalid, rready, ext_tick;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic [31:0] rdata;
	logic low_run, fast_run, fast_rdy, cpu_tick;
	logic [1:0] src;
	logic [3:0] fdiv;
	logic [3:0] cdiv;
	int failures;
	int samples_checked;
	int mdl[8];
	logic exp_rdy;
	logic [1:0] resp;
	logic [31:0] got;

	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// external source ticks every second cycle
	always @(posedge aclk) ext_tick <= aresetn & ~ext_tick;

	scs_top #(.FAST_STAB_NS(STAB_CYC * 50)) i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ext_clk_tick(ext_tick), .low_osc_run(low_run), .fast_osc_run(fast_run),
		.fast_osc_ready(fast_rdy), .sys_clk_src(src), .fast_div_log(fdiv), .cpu_div_log(cdiv),
		.cpu_tick(cpu_tick));

	// ----------------------------------------
	// compare and close
	// ----------------------------------------
	task automatic check_val(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic check_resp(input logic [1:0] g, input logic [1:0] e);
		samples_checked++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED at %0t: resp %h expected %h", $time, g, e);
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ----------------------------------------
	// bus master
	// ----------------------------------------
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 1000);
		resp = bresp;
		bready <= 1'b0;
		if (n >= 1000) failures++;
	endtask

	task automatic axi_read(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 1000);
		resp = rresp;
		got = rdata;
		rready <= 1'b0;
		if (n >= 1000) failures++;
	endtask

	// ----------------------------------------
	// reference model
	// ----------------------------------------
	function automatic logic [1:0] exp_resp(input logic [7:0] a);
		return (a[1:0] != 2'b00 || a > 8'h18) ? 2'b10 : 2'b00;
	endfunction

	// fast clock is only used once it has settled; until then the slow one stands in
	function automatic int exp_src();
		if (mdl[5][2] == 1'b0) return 0;
		return (mdl[3][1] && exp_rdy) ? 2 : 1;
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int i;
		i = a[7:2];
		axi_write(a, d, s);
		check_resp(resp, exp_resp(a));
		if (exp_resp(a) == 2'b00 && s[0] && i < 6 && (i == 0 || mdl[0][0])) mdl[i] = d[7:0];
	endtask

	task automatic rd(input logic [7:0] a);
		int i;
		int e;
		i = a[7:2];
		e = (i == 6) ? exp_src() * 16 + (exp_src() == 2) * 8 + exp_rdy * 4 + mdl[3][0] * 2
			+ !mdl[2][4] : mdl[i];
		if (exp_resp(a) != 2'b00) e = 0;
		axi_read(a);
		check_resp(resp, exp_resp(a));
		check_val(got, e);
	endtask

	task automatic read_all();
		for (int i = 0; i < 8; i++) rd(8'(i * 4));
	endtask

	task automatic check_outs();
		repeat (2) @(posedge aclk);
		#1;
		check_val(low_run, !mdl[2][4]);
		check_val(fast_run, mdl[3][0]);
		check_val(src, exp_src());
		check_val(fdiv, mdl[4][2:0] + 1);
		check_val(cdiv, mdl[1][6] ? 3 : mdl[2][7:6]);
	endtask

	// window is a whole number of divided periods, so latency does not shift the count
	task automatic count_ticks(input int lg);
		int c;
		c = 0;
		repeat (40) @(posedge aclk);
		repeat (48)
		begin
			@(posedge aclk);
			c += cpu_tick;
		end
		check_val(c, 24 >> lg);
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial
	begin
		repeat (20000) @(posedge aclk);
		failures++;
		close_out();
	end

	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, ext_tick, exp_rdy} = 8'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		failures = 0;
		samples_checked = 0;
		for (int i = 0; i < 8; i++) mdl[i] = 0;
		void'($urandom(32'hfd14286b));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		read_all();
		check_outs();
		for (int a = 4; a <= 8'h1c; a += 4) wr(a[7:0], $urandom, 4'hf);
		read_all();
		wr(8'h00, $urandom | 1, 4'hf);
		wr(8'h08, $urandom, 4'he);
		for (int b = 0; b < 2; b++)
		begin
			wr(8'h08, ($urandom & ~32'h10) | (b << 4), 4'h1);
			check_outs();
		end
		for (int c = 0; c < 8; c++)
		begin
			wr(8'h10, ($urandom & ~32'h7) | c, 4'h1);
			check_outs();
		end
		wr(8'h0c, 32'h1, 4'h1);
		check_outs();
		repeat (6) @(posedge aclk);
		#1;
		check_val(fast_rdy, 1'b0);
		repeat (3) @(posedge aclk);
		#1;
		check_val(fast_rdy, 1'b1);
		exp_rdy = 1'b1;
		wr(8'h14, 32'h4, 4'h1);
		check_outs();
		wr(8'h0c, 32'h3, 4'h1);
		check_outs();
		wr(8'h14, $urandom | 32'h4, 4'h1);
		check_outs();
		rd(8'h18);
		wr(8'h14, 32'h0, 4'h1);
		// field ends at 00 so the forced ratio below differs from the field's ratio
		for (int f = 0; f < 4; f++)
		begin
			wr(8'h08, (3 - f) << 6, 4'h1);
			check_outs();
			count_ticks(3 - f);
		end
		wr(8'h04, 32'h40, 4'h1);
		check_outs();
		count_ticks(3);
		wr(8'h04, $urandom & ~32'h40, 4'h1);
		check_outs();
		wr(8'h00, $urandom & ~32'h1, 4'hf);
		wr(8'h08, $urandom | 32'h10, 4'h1);
		wr(8'h0c, 32'h0, 4'h1);
		check_outs();
		read_all();
		close_out();
	end
endmodule
`default_nettype wire
